// >>> pkg/boot_cfg_map.svh
`ifndef BOOT_CFG_MAP_SVH
`define BOOT_CFG_MAP_SVH

// Vector field positions
`define BOOTVEC_MULT_HI    2
`define BOOTVEC_MULT_LO    0
`define BOOTVEC_ENDIAN     3
`define BOOTVEC_WIDTH_HI   6
`define BOOTVEC_WIDTH_LO   5
`define BOOTVEC_RSTMODE    7
`define BOOTVEC_WDT_OFF    8
`define BOOTVEC_PCI_HI     11
`define BOOTVEC_PCI_LO     9

// Reset values, legal codes and the reserved width code
`define BOOTVEC_RESET      16'h0000
`define MULT_X2            3'h0
`define WIDTH_RSVD         2'h3
`define RSTMODE_NORMAL     1'h0

// Least reset hold after cold reset, in clock cycles
`define RESET_HOLD_CYCLES  4096

`endif

// >>> pkg/boot_cfg_pkg.sv
package boot_cfg_pkg;

  // PCI operating modes
  typedef enum logic [2:0] {
    PCI_OFF      = 3'h0,
    PCI_SAT_NRDY = 3'h1,
    PCI_SAT_SUSP = 3'h2,
    PCI_HOST_EXT = 3'h3,
    PCI_HOST_FIX = 3'h4,
    PCI_HOST_RR  = 3'h5,
    PCI_RSVD6    = 3'h6,
    PCI_RSVD7    = 3'h7
  } pci_mode_t;

  // Decoded start-up settings
  typedef struct packed {
    logic [2:0]  cpu_mult;
    logic        big_endian;
    logic [1:0]  boot_width;
    logic        reset_mode;
    logic        wdt_enable;
    pci_mode_t   pci_mode;
    logic        pci_enable;
    logic [15:0] boot_vector_field;
  } boot_cfg_t;

  // Decoder state
  typedef struct packed {
    boot_cfg_t cfg;
    logic      err;
  } dec_state_t;

  // Reset sequencing phases
  typedef enum logic [1:0] {
    PH_COLD,
    PH_STRETCH,
    PH_RUN
  } phase_t;

  // Sequencer state
  typedef struct packed {
    phase_t      phase;
    logic [15:0] sample;
    logic        bus_oe;
    logic        boot_output_enable_n_n;
    logic        bdir_n;
    logic        rst_oe;
    logic        warm;
    logic        done;
    logic        start;
  } seq_state_t;

  // Satellite modes start with the PCI interface enabled
  function automatic logic pci_enable_init(input pci_mode_t m);
    return (m == PCI_SAT_NRDY) || (m == PCI_SAT_SUSP);
  endfunction

endpackage

// >>> rtl/boot_vector_decode.sv
`timescale 1ns/1ps
`include "boot_cfg_map.svh"
module boot_vector_decode (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // Capture request
  input  wire logic                   load,
  input  wire logic [15:0]            vector,
  // Decoded settings
  output boot_cfg_pkg::boot_cfg_t     cfg,
  output logic                        cfg_err
);
  import boot_cfg_pkg::*;

  dec_state_t s_q;
  dec_state_t s_d;

  // Decode once at the capture edge; held until the next one
  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cfg.boot_vector_field = vector;
      s_d.cfg.cpu_mult   = vector[`BOOTVEC_MULT_HI:`BOOTVEC_MULT_LO];
      s_d.cfg.big_endian = vector[`BOOTVEC_ENDIAN];
      s_d.cfg.boot_width = vector[`BOOTVEC_WIDTH_HI:`BOOTVEC_WIDTH_LO];
      s_d.cfg.reset_mode = vector[`BOOTVEC_RSTMODE];
      s_d.cfg.wdt_enable = ~vector[`BOOTVEC_WDT_OFF];
      s_d.cfg.pci_mode   = pci_mode_t'(vector[`BOOTVEC_PCI_HI:`BOOTVEC_PCI_LO]);
      s_d.cfg.pci_enable = pci_enable_init(s_d.cfg.pci_mode);
      // Reserved codes are kept as given but flagged for the system
      s_d.err = (s_d.cfg.cpu_mult != `MULT_X2) || (s_d.cfg.boot_width == `WIDTH_RSVD)
             || (s_d.cfg.reset_mode != `RSTMODE_NORMAL) || (s_d.cfg.pci_mode > PCI_HOST_RR);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg     = s_q.cfg;
  assign cfg_err = s_q.err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_field_split: assert property (load |=> cfg.big_endian == $past(vector[3])
    && cfg.wdt_enable == !$past(vector[8]) && cfg.boot_width == $past(vector[6:5]))
    else $error("decoded fields do not match vector");
  a_reserved_flag: assert property (load && vector[11:9] > 3'h5 |=> cfg_err)
    else $error("reserved PCI mode not flagged");
endmodule // boot_vector_decode

// >>> rtl/reset_hold_timer.sv
`timescale 1ns/1ps
module reset_hold_timer #(
  parameter int HOLD_CYCLES = 4096
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      done
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          busy;
    logic          done;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  // Down counter; abort wins so a new cold reset restarts the wait
  always_comb begin
    s_d = s_q;
    if (abort) begin
      s_d = '0;
    end else if (start) begin
      s_d.cnt  = CW'(HOLD_CYCLES - 1);
      s_d.busy = 1'b1;
      s_d.done = 1'b0;
    end else if (s_q.busy) begin
      if (s_q.cnt == '0) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule // reset_hold_timer

// >>> rtl/boot_config_vector_capture.sv
`timescale 1ns/1ps
`include "boot_cfg_map.svh"
module boot_config_vector_capture #(
  parameter int RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_B,
  // Cold reset from the board
  input  wire logic                   POWER_ON_RESET_IN_N,
  // Memory data bus, vector input and drive enable
  input  wire logic [15:0]            MEM_DATA_BUS_I,
  output logic                        MEM_DATA_BUS_OE,
  // Bus buffer controls
  output logic                        BOOT_OUTPUT_ENABLE_N,
  output logic                        BUFFER_DIRECTION_N,
  // System reset line, two-way
  input  wire logic                   SYSTEM_RESET_LINE_N_I,
  output logic                        SYSTEM_RESET_LINE_N_O,
  output logic                        SYSTEM_RESET_LINE_N_OE,
  // Status
  output logic                        WARM_RESET,
  output logic                        BOOT_DONE,
  // Decoded settings
  output boot_cfg_pkg::boot_cfg_t     BOOT_CFG,
  output logic                        BOOT_CFG_ERR
);
  import boot_cfg_pkg::*;

  seq_state_t s_q;
  seq_state_t s_d;
  logic       cold;
  logic       load;
  logic       hold_done;

  // Cold reset level and its negation edge
  assign cold = ~POWER_ON_RESET_IN_N;
  assign load = ~cold && (s_q.phase == PH_COLD);

  // Vector decode and settings hold
  boot_vector_decode u_decode (
    .clk     (REF_CLK),
    .rst_b   (RST_B),
    .load    (load),
    .vector  (s_q.sample),
    .cfg     (BOOT_CFG),
    .cfg_err (BOOT_CFG_ERR)
  );

  // Reset stretch after cold reset; restarts on a new cold reset
  reset_hold_timer #(
    .HOLD_CYCLES (RESET_HOLD_CYCLES)
  ) u_timer (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .start (s_q.start),
    .abort (cold),
    .done  (hold_done)
  );

  // Reset sequencer: cold overrides every phase
  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    if (cold) begin
      s_d.phase  = PH_COLD;
      s_d.sample = MEM_DATA_BUS_I;
      s_d.bus_oe = 1'b0;
      s_d.boot_output_enable_n_n = 1'b0;
      s_d.bdir_n = 1'b0;
      s_d.rst_oe = 1'b1;
      s_d.warm   = 1'b0;
      s_d.done   = 1'b0;
    end else begin
      case (s_q.phase)
        PH_COLD: begin
          // Vector already latched from the last cold cycle
          s_d.phase  = PH_STRETCH;
          s_d.start  = 1'b1;
          s_d.bus_oe = 1'b1;
          s_d.boot_output_enable_n_n = 1'b1;
          s_d.bdir_n = 1'b1;
        end
        PH_STRETCH: begin
          // Keep the line low until the hold count has run out
          if (hold_done) begin
            s_d.phase  = PH_RUN;
            s_d.rst_oe = 1'b0;
            s_d.done   = 1'b1;
          end
        end
        PH_RUN: begin
          // Line is now an input; a low level is a warm reset
          s_d.warm = ~SYSTEM_RESET_LINE_N_I;
        end
        default: begin
          s_d.phase = PH_COLD;
        end
      endcase
    end
  end

  // State register; reset state is the cold reset state, except that the sample loads BOOTVEC_RESET instead of the bus
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q        <= '0;
      s_q.phase  <= PH_COLD;
      s_q.sample <= `BOOTVEC_RESET;
      s_q.rst_oe <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops; line only ever pulled low
  assign MEM_DATA_BUS_OE        = s_q.bus_oe;
  assign BOOT_OUTPUT_ENABLE_N   = s_q.boot_output_enable_n_n;
  assign BUFFER_DIRECTION_N     = s_q.bdir_n;
  assign SYSTEM_RESET_LINE_N_O  = 1'b0;
  assign SYSTEM_RESET_LINE_N_OE = s_q.rst_oe;
  assign WARM_RESET             = s_q.warm;
  assign BOOT_DONE              = s_q.done;

  // Cycles the reset line has been held since cold negation
  logic [31:0] held_q;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      held_q <= 32'h0;
    end else if (cold) begin
      held_q <= 32'h0;
    end else if (s_q.rst_oe) begin
      held_q <= held_q + 32'h1;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  sequence cold_neg_s;
    !cold && s_q.phase == PH_COLD;
  endsequence

  sequence resume_s;
    MEM_DATA_BUS_OE && BOOT_OUTPUT_ENABLE_N && BUFFER_DIRECTION_N;
  endsequence

  a_no_sample_outside: assert property (!cold |=> $stable(s_q.sample))
    else $error("vector sampled outside cold reset");
  a_cfg_captured: assert property (load |=> BOOT_CFG.boot_vector_field == $past(s_q.sample))
    else $error("vector not latched at cold negation");
  a_cfg_stable: assert property (!load |=> $stable(BOOT_CFG))
    else $error("settings changed after capture");
  a_pci_enable_init: assert property (BOOT_DONE |-> BOOT_CFG.pci_enable == pci_enable_init(BOOT_CFG.pci_mode))
    else $error("PCI enable initial value wrong");
  a_cold_drive: assert property (cold |=> SYSTEM_RESET_LINE_N_OE && !MEM_DATA_BUS_OE
    && !BOOT_OUTPUT_ENABLE_N && !BUFFER_DIRECTION_N)
    else $error("cold reset outputs wrong");
  a_resume_drive: assert property (cold_neg_s |=> resume_s)
    else $error("bus not resumed after cold reset");
  a_rst_hold: assert property ($fell(SYSTEM_RESET_LINE_N_OE) |-> held_q >= RESET_HOLD_CYCLES)
    else $error("reset line released too early");
  a_warm_follow: assert property (s_q.phase == PH_RUN && !cold && !SYSTEM_RESET_LINE_N_I |=> WARM_RESET)
    else $error("warm reset not seen");
endmodule // boot_config_vector_capture

// >>> tb/boot_vec_source.sv
`timescale 1ns/1ps
// Board reset logic: holds cold reset low while it presents the boot vector
module boot_vec_source (
  // Clock
  input  wire logic        clk,
  // Cold reset and vector toward the device
  output logic             cold_n,
  output logic [15:0]      bus
);
  // Power-up state: cold reset held, vector not yet valid
  initial begin
    cold_n = 1'b0;
    bus    = 16'h0000;
  end

  // Cold reset of n cycles; n of 1 is a prompt board, larger a slow one
  task automatic cold_boot(input logic [15:0] v, input int n);
    @(negedge clk);
    cold_n <= 1'b0;
    bus    <= v;
    repeat (n) @(negedge clk);
    cold_n <= 1'b1;
    @(negedge clk);
    // Released bus has no pull, so show the inverse: a late sample cannot look right
    bus    <= ~v;
  endtask
endmodule // boot_vec_source

// >>> tb/boot_config_vector_capture_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module boot_config_vector_capture_tb;
  import boot_cfg_pkg::*;
  localparam int HOLD = 8;
  typedef struct packed {
    logic [15:0] vec;
    logic        pen;
    logic        err;
  } row_t;
  logic        ref_clk;
  logic        rst_b;
  logic        cold_n;
  logic [15:0] bus;
  logic        warm_pull;
  logic        bus_oe;
  logic        boot_output_enable_n_n;
  logic        bdir_n;
  logic        line_n;
  logic        line_o;
  logic        line_oe;
  logic        warm;
  logic        done;
  boot_cfg_t   cfg;
  logic        cfg_err;
  int          mismatches = 0;
  int          n_tests = 0;
  int          k;
  // Every PCI mode, width, endian and watchdog value, and a reserved code in each field
  row_t rows[12] = '{'{16'h0000, 1'b0, 1'b0}, '{16'h0218, 1'b1, 1'b0}, '{16'h0428, 1'b1, 1'b0},
                     '{16'h0740, 1'b0, 1'b0}, '{16'h8800, 1'b0, 1'b0}, '{16'h5A00, 1'b0, 1'b0},
                     '{16'h0C00, 1'b0, 1'b1}, '{16'h0E00, 1'b0, 1'b1}, '{16'h0060, 1'b0, 1'b1},
                     '{16'h0080, 1'b0, 1'b1}, '{16'h0001, 1'b0, 1'b1}, '{16'h0007, 1'b0, 1'b1}};

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Reset line has a board pull-up; device or bench may pull it low
  assign line_n = ((line_oe && !line_o) || warm_pull) ? 1'b0 : 1'b1;

  boot_vec_source src_u (.clk(ref_clk), .cold_n(cold_n), .bus(bus));

  boot_config_vector_capture #(.RESET_HOLD_CYCLES(HOLD)) dut_u (
    .REF_CLK(ref_clk), .RST_B(rst_b), .POWER_ON_RESET_IN_N(cold_n), .MEM_DATA_BUS_I(bus),
    .MEM_DATA_BUS_OE(bus_oe), .BOOT_OUTPUT_ENABLE_N(boot_output_enable_n_n), .BUFFER_DIRECTION_N(bdir_n),
    .SYSTEM_RESET_LINE_N_I(line_n), .SYSTEM_RESET_LINE_N_O(line_o),
    .SYSTEM_RESET_LINE_N_OE(line_oe), .WARM_RESET(warm), .BOOT_DONE(done),
    .BOOT_CFG(cfg), .BOOT_CFG_ERR(cfg_err));

  // Expected decode, built field by field from the vector layout
  function automatic boot_cfg_t exp_cfg(input row_t r);
    return '{r.vec[2:0], r.vec[3], r.vec[6:5], r.vec[7], ~r.vec[8],
             pci_mode_t'(r.vec[11:9]), r.pen, r.vec};
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One cold boot: cold-state outputs, capture, hold length, then no resampling
  task automatic boot_check(input row_t r, input int n);
    fork
      src_u.cold_boot(r.vec, n);
      begin
        repeat (2) @(negedge ref_clk);
        `CHK({bus_oe, boot_output_enable_n_n, bdir_n, line_oe, done}, 5'h02)
      end
    join
    @(negedge ref_clk);
    `CHK(cfg, exp_cfg(r))
    `CHK(cfg_err, r.err)
    `CHK({bus_oe, boot_output_enable_n_n, bdir_n, line_oe}, 4'hF)
    k = 1;
    while (done !== 1'b1 && k < HOLD + 40) begin
      @(negedge ref_clk);
      k++;
    end
    `CHK(k >= HOLD + 2 && k <= HOLD + 3, 1'b1)
    `CHK({line_oe, line_n}, 2'h1)
    `CHK(cfg, exp_cfg(r))
  endtask

  // Watchdog: the whole run takes a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end

  initial begin
    rst_b     = 1'b0;
    warm_pull = 1'b0;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      boot_check(rows[i], i % 3 + 1);
      $display("row %0d done", i);
    end
    // Warm reset input after boot, without recapture
    @(negedge ref_clk);
    warm_pull = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(warm, 1'b1)
    warm_pull = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(warm, 1'b0)
    `CHK(cfg, exp_cfg(rows[11]))
    $display("warm reset test done");
    // Cold reset again in mid-stretch; warm input ignored there
    src_u.cold_boot(16'h0218, 2);
    repeat (2) @(negedge ref_clk);
    warm_pull = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK({warm, done}, 2'h0)
    warm_pull = 1'b0;
    boot_check(rows[2], 2);
    $display("restart test done");
    // Asynchronous reset in mid-run returns to the cold state
    rst_b = 1'b0;
    @(negedge ref_clk);
    `CHK({bus_oe, boot_output_enable_n_n, bdir_n, line_oe, done, warm, cfg_err}, 7'h08)
    `CHK(cfg, '0)
    rst_b = 1'b1;
    // cold_n is already high at release, so the first edge ends cold and resumes the bus
    repeat (2) @(negedge ref_clk);
    `CHK({bus_oe, boot_output_enable_n_n, bdir_n, line_oe, done}, 5'h1E)
    $display("reset test done");
    wrap_up();
  end
endmodule // boot_config_vector_capture_tb
